// ### pcg_pkg.sv
// Constants shared by the port routing and simple pin logic
package pcg_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_ROUTING = 12'hB00;
    localparam logic [11:0] ADDR_ENABLES = 12'hB04;
    localparam logic [11:0] ADDR_OPEN_DRAIN = 12'hB08;
    localparam logic [11:0] ADDR_DIRECTION = 12'hB0C;
    localparam logic [11:0] ADDR_CONFLICT = 12'hB80;
    localparam logic [11:0] ADDR_OWNERSHIP = 12'hB84;
    localparam int ADDR_W = 12;

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] ROUTING_WMASK = 32'hB3F7_1F77;
    localparam logic [31:0] SIMPLE_WMASK = 32'h3F0F_3FFF;

    // ----------------------------------------------------------------
    // Routing word fields, lsb numbering (bus bit = 31 - printed bit)
    // ----------------------------------------------------------------
    localparam int F_MEM_SEL = 31;
    localparam int F_ALT_LO = 28;
    localparam int F_ATA_LO = 24;
    localparam int F_IR_CLK = 23;
    localparam int F_IR_LO = 20;
    localparam int F_ETH_LO = 16;
    localparam int F_USB1 = 12;
    localparam int F_SC3_LO = 8;
    localparam int F_SC2_LO = 4;
    localparam int F_SC1_LO = 0;

    // Field codes
    localparam logic [1:0] ATA_ON_TIMER = 2'h3;
    localparam logic [1:0] ATA_NONE = 2'h0;
    localparam logic [2:0] CODE3_GPIO = 3'h0;
    localparam logic [2:0] IR_BLASTER_REMOTE_OFF = 3'h2;
    localparam logic [2:0] SC2_CAN = 3'h1;
    localparam logic [3:0] SC3_GPIO = 4'h0;
    localparam logic [3:0] SC3_USB2 = 4'h1;
    localparam logic [1:0] SUB_ISDN = 2'h1;
    localparam logic [1:0] SUB_UART = 2'h2;
    localparam logic [1:0] SUB_CODEC = 2'h3;

    // ----------------------------------------------------------------
    // Decoded routing flags on the route output
    // ----------------------------------------------------------------
    localparam int R_MEM_SEL = 0;
    localparam int R_CAN_ALT = 1;
    localparam int R_SPI_ALT = 2;
    localparam int R_ATA_CS45 = 3;
    localparam int R_ATA_I2C2 = 4;
    localparam int R_ATA_TIMER = 5;
    localparam int R_IR_CLK_EXT = 6;
    localparam int R_IR_BLASTER = 7;
    localparam int R_IR_REMOTE = 8;
    localparam int R_IRDA = 9;
    localparam int R_ETH_USB2 = 10;
    localparam int R_ETH_7WIRE = 11;
    localparam int R_ETH_100 = 12;
    localparam int R_ETH_MGMT = 13;
    localparam int R_USB1 = 14;
    localparam int R_SC3_USB2 = 15;
    localparam int R_SC3_SPI = 16;
    localparam int R_SC3_ISDN = 17;
    localparam int R_SC3_L1RG = 18;
    localparam int R_SC3_UART = 19;
    localparam int R_SC3_CD = 20;
    localparam int R_SC3_CODEC = 21;
    localparam int R_SC2_CAN = 22;
    localparam int R_SC2_AC97 = 23;
    localparam int R_SC2_UART = 24;
    localparam int R_SC2_CD = 25;
    localparam int R_SC2_CODEC = 26;
    localparam int R_SC1_AC97 = 27;
    localparam int R_SC1_UART = 28;
    localparam int R_SC1_CD = 29;
    localparam int R_SC1_CODEC = 30;
    localparam int ROUTE_W = 31;

    // Conflict flags
    localparam int C_CAN_ALT = 0;
    localparam int C_SPI_ALT = 1;
    localparam int C_USB2_TWICE = 2;
    localparam int CONFLICT_W = 3;

    // ----------------------------------------------------------------
    // Simple pins: bus bit of each pin in the simple registers
    // ----------------------------------------------------------------
    localparam int PIN_N = 24;
    localparam int PIN_BIT [PIN_N] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13,
                                       16, 17, 18, 19, 24, 25, 26, 27, 28, 29};
    localparam int BIT_IR_CLK_PIN = 29;
    localparam int BIT_IR_TRANSMIT_PIN = 28;
    localparam int ETH_LO = 24;
    localparam int ETH_HI = 27;
    localparam int USB_LO = 16;
    localparam int USB_HI = 19;
    localparam int SC3_LO = 8;
    localparam int SC3_HI = 13;
    localparam int SC2_LO = 4;
    localparam int SC2_HI = 7;
    localparam int SC1_LO = 0;
    localparam int SC1_HI = 3;

endpackage

// ### pcg_pin_if.sv
// Per-pin control bundle between the register block and the pin drivers
`timescale 1ns/1ps
`default_nettype none

interface pcg_pin_if #(parameter int N = 24);
    logic [N-1:0] owned;
    logic [N-1:0] dir;
    logic [N-1:0] open_drain;
    logic [N-1:0] data;
    logic [N-1:0] periph_out;
    logic [N-1:0] periph_oe_n;

    modport ctrl (output owned, output dir, output open_drain, output data,
                  output periph_out, output periph_oe_n);
    modport drv (input owned, input dir, input open_drain, input data,
                 input periph_out, input periph_oe_n);
endinterface

`default_nettype wire

// ### pcg_pin_drive.sv
// Registered pin driver: GPIO or peripheral ownership and open-drain emulation
`timescale 1ns/1ps
`default_nettype none

module pcg_pin_drive #(
    parameter int N = 24
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Control bundle
    pcg_pin_if.drv ctl,
    // Pin side
    output logic [N-1:0] o_pin_out,
    output logic [N-1:0] o_pin_oe_n
);

    typedef struct packed {
        logic [N-1:0] out;
        logic [N-1:0] oe_n;
    } pcg_drv_state_t;

    pcg_drv_state_t state;
    pcg_drv_state_t next_state;

    if (N < 1) begin : g_bad_n
        $error("pcg_pin_drive: N must be at least 1");
    end

    // ----------------------------------------------------------------
    // Per-pin selection
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        for (int k = 0; k < N; k++) begin
            if (ctl.owned[k]) begin
                next_state.out[k] = ctl.open_drain[k] ? 1'b0 : ctl.data[k];
                // Drive only as output; a high in open-drain mode releases the pin
                next_state.oe_n[k] = !(ctl.dir[k] && !(ctl.open_drain[k] && ctl.data[k]));
            end else begin
                next_state.out[k] = ctl.periph_out[k];
                next_state.oe_n[k] = ctl.periph_oe_n[k];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= '{out: '0, oe_n: '1};
        end else begin
            state <= next_state;
        end
    end

    assign o_pin_out = state.out;
    assign o_pin_oe_n = state.oe_n;

endmodule // pcg_pin_drive

`default_nettype wire

// ### pcg_port_config.sv
// Port routing word, simple pin registers and APB slave
`timescale 1ns/1ps
`default_nettype none

module pcg_port_config #(
    parameter int PIN_N = pcg_pkg::PIN_N
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // GPIO data in register bus bit order, peripheral drive in simple pin order
    input wire logic [31:0] I_GPIO_DATA,
    input wire logic [PIN_N-1:0] I_PERIPH_OUT,
    input wire logic [PIN_N-1:0] I_PERIPH_OE_N,
    // Pins
    output logic [PIN_N-1:0] O_PIN_OUT,
    output logic [PIN_N-1:0] O_PIN_OE_N,
    // Routing to peripherals
    output logic [pcg_pkg::ROUTE_W-1:0] O_ROUTE,
    output logic [pcg_pkg::CONFLICT_W-1:0] O_CONFLICT
);

    typedef struct packed {
        logic [31:0] routing;
        logic [31:0] enables;
        logic [31:0] open_drain;
        logic [31:0] direction;
        logic [31:0] rdata;
        logic [pcg_pkg::ROUTE_W-1:0] route;
        logic [pcg_pkg::CONFLICT_W-1:0] conflict;
    } pcg_state_t;

    pcg_state_t state;
    pcg_state_t next_state;

    logic [31:0] gpio_routed;
    logic [31:0] owned_word;
    logic apb_setup;
    logic apb_access;
    logic addr_hit;

    if (PIN_N != pcg_pkg::PIN_N) begin : g_bad_pin_n
        $error("pcg_port_config: PIN_N must match the simple pin map");
    end

    // ----------------------------------------------------------------
    // Routing decode
    // ----------------------------------------------------------------
    function automatic logic [pcg_pkg::ROUTE_W-1:0] decode_route(input logic [31:0] w);
        logic [1:0] alt;
        logic [1:0] ata;
        logic [2:0] ir;
        logic [2:0] eth;
        logic [3:0] s3;
        logic [2:0] s2;
        logic [2:0] s1;
        logic [1:0] sub3;
        logic [pcg_pkg::ROUTE_W-1:0] r;
        alt = w[pcg_pkg::F_ALT_LO +: 2];
        ata = w[pcg_pkg::F_ATA_LO +: 2];
        ir = w[pcg_pkg::F_IR_LO +: 3];
        eth = w[pcg_pkg::F_ETH_LO +: 3];
        s3 = w[pcg_pkg::F_SC3_LO +: 4];
        s2 = w[pcg_pkg::F_SC2_LO +: 3];
        s1 = w[pcg_pkg::F_SC1_LO +: 3];
        sub3 = s3[2:1];
        r = '0;
        r[pcg_pkg::R_MEM_SEL] = w[pcg_pkg::F_MEM_SEL];
        r[pcg_pkg::R_CAN_ALT] = alt[0];
        r[pcg_pkg::R_SPI_ALT] = alt[1];
        r[pcg_pkg::R_ATA_CS45] = (ata == 2'h1);
        r[pcg_pkg::R_ATA_I2C2] = (ata == 2'h2);
        r[pcg_pkg::R_ATA_TIMER] = (ata == pcg_pkg::ATA_ON_TIMER);
        r[pcg_pkg::R_IR_CLK_EXT] = w[pcg_pkg::F_IR_CLK];
        r[pcg_pkg::R_IR_BLASTER] = !ir[2] && ir[0];
        r[pcg_pkg::R_IR_REMOTE] = ir[1];
        r[pcg_pkg::R_IRDA] = ir[2];
        r[pcg_pkg::R_ETH_USB2] = !eth[2] && eth[0];
        r[pcg_pkg::R_ETH_7WIRE] = !eth[2] && eth[1];
        r[pcg_pkg::R_ETH_100] = eth[2];
        r[pcg_pkg::R_ETH_MGMT] = eth[2] && (eth[1] || eth[0]);
        r[pcg_pkg::R_USB1] = w[pcg_pkg::F_USB1];
        r[pcg_pkg::R_SC3_USB2] = (s3 == pcg_pkg::SC3_USB2);
        r[pcg_pkg::R_SC3_SPI] = s3[3];
        r[pcg_pkg::R_SC3_ISDN] = (sub3 == pcg_pkg::SUB_ISDN);
        r[pcg_pkg::R_SC3_L1RG] = (sub3 == pcg_pkg::SUB_ISDN) && s3[0];
        r[pcg_pkg::R_SC3_UART] = (sub3 == pcg_pkg::SUB_UART);
        r[pcg_pkg::R_SC3_CD] = (sub3 == pcg_pkg::SUB_UART) && s3[0];
        r[pcg_pkg::R_SC3_CODEC] = (sub3 == pcg_pkg::SUB_CODEC);
        r[pcg_pkg::R_SC2_CAN] = (s2 == pcg_pkg::SC2_CAN);
        r[pcg_pkg::R_SC2_AC97] = (s2[2:1] == pcg_pkg::SUB_ISDN);
        r[pcg_pkg::R_SC2_UART] = (s2[2:1] == pcg_pkg::SUB_UART);
        r[pcg_pkg::R_SC2_CD] = (s2[2:1] == pcg_pkg::SUB_UART) && s2[0];
        r[pcg_pkg::R_SC2_CODEC] = (s2[2:1] == pcg_pkg::SUB_CODEC);
        r[pcg_pkg::R_SC1_AC97] = (s1[2:1] == pcg_pkg::SUB_ISDN);
        r[pcg_pkg::R_SC1_UART] = (s1[2:1] == pcg_pkg::SUB_UART);
        r[pcg_pkg::R_SC1_CD] = (s1[2:1] == pcg_pkg::SUB_UART) && s1[0];
        r[pcg_pkg::R_SC1_CODEC] = (s1[2:1] == pcg_pkg::SUB_CODEC);
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Forbidden combinations, reported but not blocked
    // ----------------------------------------------------------------
    function automatic logic [pcg_pkg::CONFLICT_W-1:0] detect_conflict(input logic [31:0] w);
        logic [pcg_pkg::CONFLICT_W-1:0] c;
        logic [2:0] eth;
        eth = w[pcg_pkg::F_ETH_LO +: 3];
        c = '0;
        c[pcg_pkg::C_CAN_ALT] = w[pcg_pkg::F_ALT_LO]
            && ((w[pcg_pkg::F_ATA_LO +: 2] == pcg_pkg::ATA_ON_TIMER)
                || (w[pcg_pkg::F_SC2_LO +: 3] == pcg_pkg::SC2_CAN));
        c[pcg_pkg::C_SPI_ALT] = w[pcg_pkg::F_ALT_LO + 1] && w[pcg_pkg::F_SC3_LO + 3];
        c[pcg_pkg::C_USB2_TWICE] = !eth[2] && eth[0]
            && (w[pcg_pkg::F_SC3_LO +: 4] == pcg_pkg::SC3_USB2);
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Which simple pins the routing word leaves to GPIO
    // ----------------------------------------------------------------
    always_comb begin
        gpio_routed = '0;
        gpio_routed[pcg_pkg::BIT_IR_CLK_PIN] = !state.routing[pcg_pkg::F_IR_CLK];
        gpio_routed[pcg_pkg::BIT_IR_TRANSMIT_PIN] = (state.routing[pcg_pkg::F_IR_LO +: 3] == pcg_pkg::CODE3_GPIO)
            || (state.routing[pcg_pkg::F_IR_LO +: 3] == pcg_pkg::IR_BLASTER_REMOTE_OFF);
        gpio_routed[pcg_pkg::ETH_HI:pcg_pkg::ETH_LO] = {4{!state.routing[pcg_pkg::F_ETH_LO + 2]
            && !state.routing[pcg_pkg::F_ETH_LO + 1]}};
        gpio_routed[pcg_pkg::USB_HI:pcg_pkg::USB_LO] = {4{!state.routing[pcg_pkg::F_USB1]}};
        gpio_routed[pcg_pkg::SC3_HI:pcg_pkg::SC3_LO] =
            {6{state.routing[pcg_pkg::F_SC3_LO +: 4] == pcg_pkg::SC3_GPIO}};
        gpio_routed[pcg_pkg::SC2_HI:pcg_pkg::SC2_LO] =
            {4{state.routing[pcg_pkg::F_SC2_LO +: 3] == pcg_pkg::CODE3_GPIO}};
        gpio_routed[pcg_pkg::SC1_HI:pcg_pkg::SC1_LO] =
            {4{state.routing[pcg_pkg::F_SC1_LO + 2 -: 2] == 2'h0}};
    end

    assign owned_word = gpio_routed & state.enables;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign apb_setup = I_PSEL && !I_PENABLE;
    assign apb_access = I_PSEL && I_PENABLE;

    always_comb begin
        unique case (I_PADDR)
            pcg_pkg::ADDR_ROUTING, pcg_pkg::ADDR_ENABLES, pcg_pkg::ADDR_OPEN_DRAIN,
            pcg_pkg::ADDR_DIRECTION, pcg_pkg::ADDR_CONFLICT, pcg_pkg::ADDR_OWNERSHIP: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Read data is fetched in the setup cycle and held for the access cycle
        if (apb_setup) begin
            unique case (I_PADDR)
                pcg_pkg::ADDR_ROUTING: next_state.rdata = state.routing;
                pcg_pkg::ADDR_ENABLES: next_state.rdata = state.enables;
                pcg_pkg::ADDR_OPEN_DRAIN: next_state.rdata = state.open_drain;
                pcg_pkg::ADDR_DIRECTION: next_state.rdata = state.direction;
                pcg_pkg::ADDR_CONFLICT: next_state.rdata = {{(32 - pcg_pkg::CONFLICT_W){1'b0}}, state.conflict};
                pcg_pkg::ADDR_OWNERSHIP: next_state.rdata = owned_word;
                default: next_state.rdata = pcg_pkg::RESET_WORD;
            endcase
        end
        if (apb_access && I_PWRITE) begin
            unique case (I_PADDR)
                pcg_pkg::ADDR_ROUTING: next_state.routing = I_PWDATA & pcg_pkg::ROUTING_WMASK;
                pcg_pkg::ADDR_ENABLES: next_state.enables = I_PWDATA & pcg_pkg::SIMPLE_WMASK;
                pcg_pkg::ADDR_OPEN_DRAIN: next_state.open_drain = I_PWDATA & pcg_pkg::SIMPLE_WMASK;
                pcg_pkg::ADDR_DIRECTION: next_state.direction = I_PWDATA & pcg_pkg::SIMPLE_WMASK;
                default: next_state.routing = state.routing;
            endcase
        end
        next_state.route = decode_route(next_state.routing);
        next_state.conflict = detect_conflict(next_state.routing);
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign O_PRDATA = state.rdata;
    assign O_PREADY = apb_access;
    assign O_PSLVERR = apb_access && !addr_hit;
    assign O_ROUTE = state.route;
    assign O_CONFLICT = state.conflict;

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    pcg_pin_if #(.N(PIN_N)) pins ();

    for (genvar k = 0; k < PIN_N; k++) begin : g_pin
        // Printed bit order runs msb first, so a higher printed bit is a lower bus bit
        assign pins.owned[k] = owned_word[pcg_pkg::PIN_BIT[k]];
        assign pins.dir[k] = state.direction[pcg_pkg::PIN_BIT[k]];
        assign pins.open_drain[k] = state.open_drain[pcg_pkg::PIN_BIT[k]];
        assign pins.data[k] = I_GPIO_DATA[pcg_pkg::PIN_BIT[k]];
        assign pins.periph_out[k] = I_PERIPH_OUT[k];
        assign pins.periph_oe_n[k] = I_PERIPH_OE_N[k];
    end

    pcg_pin_drive #(.N(PIN_N)) u_drive (
        .i_clock(I_CLOCK),
        .i_resetn(I_RESETN),
        .ctl(pins.drv),
        .o_pin_out(O_PIN_OUT),
        .o_pin_oe_n(O_PIN_OE_N)
    );

endmodule // pcg_port_config

`default_nettype wire

// ### pcg_periph_model.sv
// Peripheral side model driving the even simple pins and releasing the odd ones when GPIO does not own them
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model #(
    parameter int N = 24
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Peripheral drive
    output logic [N-1:0] o_out,
    output logic [N-1:0] o_oe_n
);
    // Output level flips every cycle, so a stale sample never passes
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_out <= '0;
        end else begin
            o_out <= ~o_out;
        end
    end
    // Mixed enables: some pins driven, some released
    assign o_oe_n = {(N/2){2'b10}};
endmodule // pcg_periph_model
`default_nettype wire

// ### pcg_port_config_assertions.sv
// Port-level checks for the port routing block
`timescale 1ns/1ps
`default_nettype none
module pcg_port_config_assertions (
    input wire logic I_CLOCK, I_RESETN, I_PSEL, I_PENABLE, I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA, O_PRDATA,
    input wire logic O_PREADY, O_PSLVERR,
    input wire logic [pcg_pkg::ROUTE_W-1:0] O_ROUTE,
    input wire logic [pcg_pkg::CONFLICT_W-1:0] O_CONFLICT
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);
    logic acc, hit;
    assign acc = I_PSEL && I_PENABLE;
    assign hit = I_PADDR inside {12'hB00, 12'hB04, 12'hB08, 12'hB0C, 12'hB80, 12'hB84};
    sequence setup_route;
        I_PSEL && !I_PENABLE && I_PWRITE && I_PADDR == 12'hB00;
    endsequence
    sequence write_route;
        setup_route ##1 acc;
    endsequence
    ready_zero_wait_a: assert property (acc |-> O_PREADY && O_PSLVERR == !hit)
        else $error("ready or error flag wrong");
    unmapped_read_a: assert property (acc && !hit && !I_PWRITE |-> O_PRDATA == 32'h0000_0000)
        else $error("unmapped read data not zero");
    mem_select_a: assert property (write_route |=> O_ROUTE[0] == $past(I_PWDATA[31]))
        else $error("memory select flag wrong");
    alt_place_a: assert property (write_route |=> O_ROUTE[2:1] == $past(I_PWDATA[29:28]))
        else $error("alternate placement flags wrong");
    ata_timer_a: assert property (write_route |=> O_ROUTE[5] == ($past(I_PWDATA[25:24]) == 2'h3))
        else $error("ATA timer flag wrong");
    clock_source_a: assert property (write_route |=> O_ROUTE[6] == $past(I_PWDATA[23]))
        else $error("clock source flag wrong");
    usb_primary_a: assert property (write_route |=> O_ROUTE[14] == $past(I_PWDATA[12]))
        else $error("primary USB flag wrong");
    can_clash_a: assert property (write_route |=> O_CONFLICT[0] == ($past(I_PWDATA[28])
        && ($past(I_PWDATA[25:24]) == 2'h3 || $past(I_PWDATA[6:4]) == 3'h1))) else $error("CAN clash flag wrong");
    reset_zero_a: assert property ($rose(I_RESETN) |-> O_ROUTE == '0 && O_CONFLICT == '0)
        else $error("routing not zero after reset");
endmodule // pcg_port_config_assertions
bind pcg_port_config pcg_port_config_assertions chk (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_ROUTE(O_ROUTE), .O_CONFLICT(O_CONFLICT));
`default_nettype wire

// ### pcg_port_config_bench.sv
// Self-checking bench for the port routing block
`timescale 1ns/1ps
`default_nettype none
module pcg_port_config_bench;
    logic I_CLOCK, I_RESETN, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, err;
    logic [11:0] I_PADDR;
    logic [31:0] I_PWDATA, I_GPIO_DATA, O_PRDATA, rd, w;
    logic [23:0] I_PERIPH_OUT, I_PERIPH_OE_N, O_PIN_OUT, O_PIN_OE_N;
    logic [30:0] O_ROUTE;
    logic [2:0] O_CONFLICT;
    int error_cnt = 0;
    int checks_done = 0;
    localparam logic [31:0] OD = 32'h1505_1505;
    localparam logic [31:0] DIR = 32'h2A0F_0F33;
    pcg_port_config #(.PIN_N(24)) uut (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_GPIO_DATA(I_GPIO_DATA),
        .I_PERIPH_OUT(I_PERIPH_OUT), .I_PERIPH_OE_N(I_PERIPH_OE_N), .O_PIN_OUT(O_PIN_OUT),
        .O_PIN_OE_N(O_PIN_OE_N), .O_ROUTE(O_ROUTE), .O_CONFLICT(O_CONFLICT));
    pcg_periph_model #(.N(24)) periph (.i_clock(I_CLOCK), .i_resetn(I_RESETN),
        .o_out(I_PERIPH_OUT), .o_oe_n(I_PERIPH_OE_N));
    // ----------------------------------------------------------------
    // Compare, bus and verdict tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge I_CLOCK);
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= wr;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLOCK);
        I_PENABLE <= 1'b1;
        @(posedge I_CLOCK);
        while (O_PREADY !== 1'b1)
            @(posedge I_CLOCK);
        rd = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Expected routing, conflicts and ownership
    // ----------------------------------------------------------------
    function automatic logic [30:0] exp_route(input logic [31:0] v);
        logic [3:0] s3;
        logic [2:0] ir, et, s2, s1;
        s3 = v[11:8];
        ir = v[22:20];
        et = v[18:16];
        s2 = v[6:4];
        s1 = v[2:0];
        return {s1[2:1] == 3, s1 == 5, s1[2:1] == 2, s1[2:1] == 1, s2[2:1] == 3, s2 == 5, s2[2:1] == 2,
            s2[2:1] == 1, s2 == 1, s3[2:1] == 3, s3[2:1] == 2 && s3[0], s3[2:1] == 2, s3[2:1] == 1 && s3[0],
            s3[2:1] == 1, s3[3], s3 == 1, v[12], et == 5 || et[2:1] == 3, et[2], et[2:1] == 1,
            !et[2] && et[0], ir[2], ir == 2 || ir == 3 || ir[2:1] == 3, ir == 1 || ir == 3, v[23],
            v[25:24] == 3, v[25:24] == 2, v[25:24] == 1, v[29:28], v[31]};
    endfunction
    function automatic logic [2:0] exp_clash(input logic [31:0] v);
        return {(v[18:16] == 1 || v[18:16] == 3) && v[11:8] == 1, v[29] && v[11],
            v[28] && (v[25:24] == 3 || v[6:4] == 1)};
    endfunction
    function automatic logic [31:0] exp_own(input logic [31:0] v);
        return {2'b00, !v[23], v[22:20] == 0 || v[22:20] == 2, {4{v[18:17] == 0}}, 4'h0, {4{!v[12]}},
            2'b00, {6{v[11:8] == 0}}, {4{v[6:4] == 0}}, {4{v[2:1] == 0}}};
    endfunction
    task automatic chk_pins(input logic [31:0] own);
        logic [23:0] eo, ee;
        int b;
        for (int k = 0; k < 24; k++) begin
            b = pcg_pkg::PIN_BIT[k];
            eo[k] = own[b] ? (!OD[b] && I_GPIO_DATA[b]) : ~I_PERIPH_OUT[k];
            ee[k] = own[b] ? !(DIR[b] && !(OD[b] && I_GPIO_DATA[b])) : I_PERIPH_OE_N[k];
        end
        chk_word({8'h00, O_PIN_OUT}, {8'h00, eo});
        chk_word({8'h00, O_PIN_OE_N}, {8'h00, ee});
    endtask
    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        I_CLOCK = 1'b0;
        forever #20 I_CLOCK = ~I_CLOCK;
    end
    initial begin
        repeat (5000) @(posedge I_CLOCK);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {I_RESETN, I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} = '0;
        I_GPIO_DATA = 32'h3C35_5A69;
        repeat (6) @(posedge I_CLOCK);
        I_RESETN <= 1'b1;
        for (int k = 0; k < 24; k++)
            rd_chk(12'hB00 + 12'(4 * (k % 6)), 32'h0000_0000);
        @(negedge I_CLOCK);
        chk_pins(32'h0000_0000);
        apb(1'b1, 12'hB00, 32'hFFFF_FFFF);
        rd_chk(12'hB00, pcg_pkg::ROUTING_WMASK);
        apb(1'b1, 12'hB04, 32'hFFFF_FFFF);
        rd_chk(12'hB04, pcg_pkg::SIMPLE_WMASK);
        apb(1'b1, 12'hB08, OD);
        apb(1'b1, 12'hB0C, DIR);
        rd_chk(12'hB0C, DIR & pcg_pkg::SIMPLE_WMASK);
        apb(1'b1, 12'hB10, 32'hFFFF_FFFF);
        chk_word({31'h0, err}, 32'h0000_0001);
        rd_chk(12'hB10, 32'h0000_0000);
        chk_word({31'h0, err}, 32'h0000_0001);
        apb(1'b1, 12'hB80, 32'hFFFF_FFFF);
        chk_word({31'h0, err}, 32'h0000_0000);
        rd_chk(12'hB80, {29'h0, exp_clash(32'hFFFF_FFFF)});
        for (int i = 0; i < 16; i++) begin
            w = {i[0], 1'b0, i[1:0], 2'b00, i[2:1], i[3], i[2:0], 1'b0, i[2:0], 3'h0, i[0], i[3:0],
                1'b0, i[2:0], 1'b0, 3'(i + 3)};
            apb(1'b1, 12'hB00, w);
            // Routing flags settle with the write edge; look once they stand
            @(negedge I_CLOCK);
            chk_word({1'b0, O_ROUTE}, {1'b0, exp_route(w)});
            rd_chk(12'hB80, {29'h0, exp_clash(w)});
            rd_chk(12'hB84, exp_own(w));
            @(negedge I_CLOCK);
            chk_pins(exp_own(w));
        end
        end_of_test();
    end
endmodule // pcg_port_config_bench
`default_nettype wire
